// ### dap_bus_model.sv
`timescale 1ns/1ps
module dap_bus_model (
    input  wire logic        clk_i,
    input  wire logic        en_i,
    input  wire logic [15:0] data_word_i,
    input  wire logic [15:0] prog_word_i,
    output logic [15:0]      data_bus_o,
    output logic [15:0]      prog_bus_o
);
    logic [15:0] last_d_ff = 16'h0000;
    logic [15:0] last_p_ff = 16'h0000;
    always_ff @(posedge clk_i) begin
        if (en_i) begin
            last_d_ff <= data_word_i;
            last_p_ff <= prog_word_i;
        end
    end
    // released buses show the inverse of the last word, so stale data never looks fresh
    assign data_bus_o = en_i ? data_word_i : ~last_d_ff;
    assign prog_bus_o = en_i ? prog_word_i : ~last_p_ff;
endmodule

// ### dap_datapath.sv
`timescale 1ns/1ps
`include "dap_map.svh"
// Contract
// - scaling shifter takes 16-bit bus operand, gives 32-bit ALU input
// - shift left zero to sixteen places, amount from instruction field
// - vacated low bits of shifted result are always zero
// - upper bits zero or sign filled per sign extension mode bit
// - ALU takes accumulator plus product register or shifter output
// - ALU result written back into the accumulator
// - ALU and accumulator operations finish in one cycle
// - accumulator stored as selectable high or low 16-bit half
// - output shifter shifts stored half, accumulator left unchanged
// - branch conditions from ALU status or selected data bit
// - jump target address taken from accumulator
// - normalization of fixed-point accumulator value
// - test instruction-selected bit of data word, report condition
// - 16x16 multiply to 32-bit product, signed or unsigned, one cycle
// - multiplier operand register holds value until reloaded
// - product register captures result and feeds ALU selector
// - four selectable shift modes on product register output
// - multiply-accumulate takes program and data bus operands each cycle
module dap_datapath #(
    parameter int DATA_W = `DAP_DATA_W,
    parameter int ACC_W  = `DAP_ACC_W
) (
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire dap_pkg::dap_cmd_s cmd_i,
    input  wire logic [15:0]       data_bus_i,
    input  wire logic [15:0]       prog_bus_i,
    output logic [31:0]            acc_o,
    output logic [31:0]            product_o,
    output logic [15:0]            store_data_o,
    output logic                   store_valid_o,
    output logic                   bit_cond_o,
    output logic                   bit_valid_o,
    output logic [15:0]            jump_addr_o,
    output logic                   jump_valid_o,
    output logic                   zero_o,
    output logic                   neg_o,
    output logic                   carry_o
);
    dap_pkg::dap_state_s st_ff;
    dap_pkg::dap_state_s nxt_st;

    logic [31:0] shifted;
    logic [31:0] prod_shifted;
    logic [31:0] operand_b;
    logic [32:0] sum;
    logic [31:0] alu_res;
    logic [31:0] mul_res;
    logic [15:0] half;
    logic [31:0] mul_sx_a;
    logic [31:0] mul_sx_b;
    logic [15:0] mul_a;
    logic [4:0]  amt;

    // amounts above sixteen are clamped so the field cannot overrun the 32-bit path
    assign amt = (cmd_i.shift_amt > 5'd16) ? 5'd16 : cmd_i.shift_amt;

    always_comb begin
        logic [31:0] ext;
        ext = {16'h0000, data_bus_i};
        if (cmd_i.sign_extend_enable) begin
            ext = {{16{data_bus_i[`DAP_SIGN_BIT]}}, data_bus_i};
        end
        shifted = ext << amt;
    end

    always_comb begin
        case (cmd_i.psh_mode)
            dap_pkg::DAP_PSH_NONE:   prod_shifted = st_ff.product_holding_reg;
            dap_pkg::DAP_PSH_LEFT1:  prod_shifted = {st_ff.product_holding_reg[30:0], 1'b0};
            dap_pkg::DAP_PSH_LEFT4:  prod_shifted = {st_ff.product_holding_reg[27:0], 4'h0};
            default:                 prod_shifted = {{6{st_ff.product_holding_reg[31]}},
                                                     st_ff.product_holding_reg[31:6]};
        endcase
    end

    assign operand_b = cmd_i.src_prod ? prod_shifted : shifted;

    // a fresh operand loaded this cycle multiplies at once, giving full multiply-accumulate rate
    assign mul_a = cmd_i.load_opnd ? data_bus_i : st_ff.multiplier_operand_reg;

    // the low half of a product of sign-extended words is the signed product
    assign mul_sx_a = {{16{mul_a[15]}}, mul_a};
    assign mul_sx_b = {{16{prog_bus_i[15]}}, prog_bus_i};

    always_comb begin
        if (cmd_i.mul_signed) begin
            mul_res = mul_sx_a * mul_sx_b;
        end else begin
            mul_res = {16'h0000, mul_a} * {16'h0000, prog_bus_i};
        end
    end

    always_comb begin
        sum = 33'h0_0000_0000;
        alu_res = st_ff.acc;
        case (cmd_i.op)
            dap_pkg::DAP_OP_ADD: begin
                sum = {1'b0, st_ff.acc} + {1'b0, operand_b};
                alu_res = sum[31:0];
            end
            dap_pkg::DAP_OP_SUB: begin
                sum = {1'b0, st_ff.acc} - {1'b0, operand_b};
                alu_res = sum[31:0];
            end
            dap_pkg::DAP_OP_AND: alu_res = st_ff.acc & operand_b;
            dap_pkg::DAP_OP_OR:  alu_res = st_ff.acc | operand_b;
            dap_pkg::DAP_OP_XOR: alu_res = st_ff.acc ^ operand_b;
            dap_pkg::DAP_OP_LD:  alu_res = operand_b;
            dap_pkg::DAP_OP_NRM: begin
                // one normalize step per cycle; software repeats until sign and next bit differ
                if (st_ff.acc != 32'h0000_0000 && st_ff.acc[31] == st_ff.acc[30]) begin
                    alu_res = {st_ff.acc[30:0], 1'b0};
                end
            end
            default: alu_res = st_ff.acc;
        endcase
    end

    always_comb begin
        half = cmd_i.store_high ? st_ff.acc[31:16] : st_ff.acc[15:0];
        if (cmd_i.store_high) begin
            half = 16'(st_ff.acc << cmd_i.store_shift >> 16);
        end else begin
            half = 16'(st_ff.acc << cmd_i.store_shift);
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.store_valid = 1'b0;
        nxt_st.bit_valid = 1'b0;
        nxt_st.jump_valid = 1'b0;
        if (cmd_i.valid) begin
            if (cmd_i.op != dap_pkg::DAP_OP_NOP) begin
                nxt_st.acc = alu_res;
                nxt_st.zero = (alu_res == 32'h0000_0000);
                nxt_st.neg = alu_res[31];
                nxt_st.carry = sum[32];
            end
            if (cmd_i.load_opnd) begin
                nxt_st.multiplier_operand_reg = data_bus_i;
            end
            if (cmd_i.mul_go) begin
                nxt_st.product_holding_reg = mul_res;
            end
            if (cmd_i.store_go) begin
                nxt_st.store_data = half;
                nxt_st.store_valid = 1'b1;
            end
            if (cmd_i.bit_test_go) begin
                nxt_st.bit_cond = data_bus_i[4'hf - cmd_i.bit_sel];
                nxt_st.bit_valid = 1'b1;
            end
            if (cmd_i.jump_go) begin
                nxt_st.jump_addr = st_ff.acc[15:0];
                nxt_st.jump_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign acc_o         = st_ff.acc;
    assign product_o     = st_ff.product_holding_reg;
    assign store_data_o  = st_ff.store_data;
    assign store_valid_o = st_ff.store_valid;
    assign bit_cond_o    = st_ff.bit_cond;
    assign bit_valid_o   = st_ff.bit_valid;
    assign jump_addr_o   = st_ff.jump_addr;
    assign jump_valid_o  = st_ff.jump_valid;
    assign zero_o        = st_ff.zero;
    assign neg_o         = st_ff.neg;
    assign carry_o       = st_ff.carry;

    AST_ACC_WRITEBACK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.op == dap_pkg::DAP_OP_LD |=> acc_o == $past(operand_b))
        else $error("accumulator missed load result");
    AST_STORE_KEEPS_ACC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.store_go && cmd_i.op == dap_pkg::DAP_OP_NOP |=> $stable(acc_o))
        else $error("store altered accumulator");
    AST_OPND_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(cmd_i.valid && cmd_i.load_opnd) |=> $stable(st_ff.multiplier_operand_reg))
        else $error("operand register changed without load");
    AST_LOW_ZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        amt != 5'd0 |-> (shifted & ((32'h0000_0001 << amt) - 32'h0000_0001)) == 32'h0000_0000)
        else $error("vacated low bits not zero");
    AST_SIGN_FILL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.sign_extend_enable && data_bus_i[15] |-> shifted[31])
        else $error("sign not replicated");
    AST_ZERO_FILL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !cmd_i.sign_extend_enable |-> (shifted >> amt) == {16'h0000, data_bus_i})
        else $error("upper bits not zero filled");
    AST_PRODUCT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.mul_go && !cmd_i.mul_signed
        |=> product_o == {16'h0000, $past(mul_a)} * {16'h0000, $past(prog_bus_i)})
        else $error("unsigned product wrong");
    AST_PSH_NONE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.psh_mode == dap_pkg::DAP_PSH_NONE |-> prod_shifted == product_o)
        else $error("mode zero shifted product");

    // multi-step behaviours are built from named sequences
    sequence seq_jump_cmd;
        cmd_i.valid && cmd_i.jump_go;
    endsequence

    sequence seq_jump_report;
        jump_valid_o && jump_addr_o == $past(acc_o[15:0]);
    endsequence

    // a second jump right behind the first keeps the pulse high for one more cycle
    sequence seq_jump_release;
        !jump_valid_o || $past(cmd_i.valid && cmd_i.jump_go);
    endsequence

    sequence seq_bit_cmd;
        cmd_i.valid && cmd_i.bit_test_go;
    endsequence

    sequence seq_bit_report;
        bit_valid_o && bit_cond_o == $past(data_bus_i[4'hf - cmd_i.bit_sel]);
    endsequence

    sequence seq_mac_cmd;
        cmd_i.valid && cmd_i.load_opnd && cmd_i.mul_go && !cmd_i.mul_signed;
    endsequence

    AST_JUMP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        seq_jump_cmd |=> seq_jump_report ##1 seq_jump_release)
        else $error("jump target not from accumulator");

    AST_BIT_TEST: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        seq_bit_cmd |=> seq_bit_report)
        else $error("tested bit not reported");

    AST_BIT_PULSE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        bit_valid_o |-> $past(cmd_i.valid && cmd_i.bit_test_go))
        else $error("bit condition reported without a test");

    AST_MAC_RATE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        seq_mac_cmd |=> product_o == {16'h0000, $past(data_bus_i)} * {16'h0000, $past(prog_bus_i)})
        else $error("multiply did not use the operand loaded with it");

    // signed product as the unsigned one less the two sign corrections, modulo two to the 32
    AST_SIGNED_PRODUCT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.mul_go && cmd_i.mul_signed
        |=> product_o == {16'h0000, $past(mul_a)} * {16'h0000, $past(prog_bus_i)}
            - ($past(mul_a[15]) ? {$past(prog_bus_i), 16'h0000} : 32'h0000_0000)
            - ($past(prog_bus_i[15]) ? {$past(mul_a), 16'h0000} : 32'h0000_0000))
        else $error("signed product wrong");

    AST_PROD_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(cmd_i.valid && cmd_i.mul_go) |=> $stable(product_o))
        else $error("product register changed without a multiply");

    AST_IDLE_KEEPS_ACC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !cmd_i.valid || cmd_i.op == dap_pkg::DAP_OP_NOP
        |=> $stable(acc_o) && $stable(zero_o) && $stable(neg_o) && $stable(carry_o))
        else $error("accumulator or flags changed without an operation");

    AST_ADD_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.op == dap_pkg::DAP_OP_ADD && !cmd_i.src_prod
        |=> acc_o == $past(acc_o) + $past(shifted))
        else $error("add not finished in one cycle");

    AST_PSH_LEFT1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.op == dap_pkg::DAP_OP_LD && cmd_i.src_prod &&
        cmd_i.psh_mode == dap_pkg::DAP_PSH_LEFT1 |=> acc_o == {$past(product_o[30:0]), 1'b0})
        else $error("product left shift by one wrong");

    AST_PSH_RIGHT6: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.op == dap_pkg::DAP_OP_LD && cmd_i.src_prod &&
        cmd_i.psh_mode == dap_pkg::DAP_PSH_RIGHT6 |=> acc_o == {{6{$past(product_o[31])}}, $past(product_o[31:6])})
        else $error("product right shift by six wrong");

    AST_NRM_SHIFT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.op == dap_pkg::DAP_OP_NRM && acc_o != 32'h0000_0000 && acc_o[31] == acc_o[30]
        |=> acc_o == {$past(acc_o[30:0]), 1'b0})
        else $error("normalize step missing");

    AST_NRM_DONE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.op == dap_pkg::DAP_OP_NRM && acc_o[31] != acc_o[30] |=> $stable(acc_o))
        else $error("normalized value shifted again");

    AST_FLAGS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.op != dap_pkg::DAP_OP_NOP
        |=> zero_o == (acc_o == 32'h0000_0000) && neg_o == acc_o[31])
        else $error("status flags disagree with accumulator");

    AST_SHIFT_FULL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        amt == 5'h10 |-> shifted == {data_bus_i, 16'h0000})
        else $error("sixteen place shift wrong");

    AST_STORE_LOW: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.store_go && !cmd_i.store_high && cmd_i.store_shift == 3'h0
        |=> store_valid_o && store_data_o == $past(acc_o[15:0]))
        else $error("low half store wrong");

    AST_STORE_HIGH_SHIFT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_i.valid && cmd_i.store_go && cmd_i.store_high && cmd_i.store_shift == 3'h1
        |=> store_valid_o && store_data_o == $past(acc_o[30:15]))
        else $error("shifted high half store wrong");

    AST_STORE_PULSE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        store_valid_o |-> $past(cmd_i.valid && cmd_i.store_go))
        else $error("store pulse without a store");
endmodule

// ### dap_map.svh
`ifndef DAP_MAP_SVH
`define DAP_MAP_SVH
`define DAP_DATA_W        16
`define DAP_ACC_W         32
`define DAP_SHIFT_MAX     16
`define DAP_SIGN_BIT      15
`define DAP_ACC_RST       32'h0000_0000
`define DAP_PROD_RST      32'h0000_0000
`define DAP_OPND_RST      16'h0000
`endif

// ### dap_pkg.sv
package dap_pkg;
    typedef enum logic [2:0] {
        DAP_OP_ADD = 3'h0,
        DAP_OP_SUB = 3'h1,
        DAP_OP_AND = 3'h2,
        DAP_OP_OR  = 3'h3,
        DAP_OP_XOR = 3'h4,
        DAP_OP_LD  = 3'h5,
        DAP_OP_NRM = 3'h6,
        DAP_OP_NOP = 3'h7
    } dap_op_e;

    typedef enum logic [1:0] {
        DAP_PSH_NONE  = 2'h0,
        DAP_PSH_LEFT1 = 2'h1,
        DAP_PSH_LEFT4 = 2'h2,
        DAP_PSH_RIGHT6 = 2'h3
    } dap_psh_e;

    typedef struct packed {
        logic        valid;
        dap_op_e     op;
        logic        src_prod;
        logic [4:0]  shift_amt;
        logic        sign_extend_enable;
        logic        load_opnd;
        logic        mul_go;
        logic        mul_signed;
        dap_psh_e    psh_mode;
        logic        store_go;
        logic        store_high;
        logic [2:0]  store_shift;
        logic        bit_test_go;
        logic [3:0]  bit_sel;
        logic        jump_go;
    } dap_cmd_s;

    typedef struct packed {
        logic [31:0] acc;
        logic [31:0] product_holding_reg;
        logic [15:0] multiplier_operand_reg;
        logic [15:0] store_data;
        logic        store_valid;
        logic        bit_cond;
        logic        bit_valid;
        logic [15:0] jump_addr;
        logic        jump_valid;
        logic        zero;
        logic        neg;
        logic        carry;
    } dap_state_s;
endpackage

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic              clk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    dap_pkg::dap_cmd_s cmd = '0;
    logic [15:0]       dw = 16'h0000;
    logic [15:0]       pw = 16'h0000;
    logic [15:0]       db, pb, sd, ja;
    logic [31:0]       acc, prod, e_acc, e_prd, rs = 32'h0000_afae;
    logic [15:0]       e_opr, e_sd, e_ja;
    logic              sv, bc, bv, jv, zf, nf, cf, e_bc;
    logic              e_zf = 1'b0, e_ng = 1'b0, e_cy = 1'b0;
    int                errors = 0;
    int                n_checks = 0;
    int                cyc = 0;
    dap_bus_model u_dap_bus_model (.clk_i(clk_i), .en_i(cmd.valid), .data_word_i(dw), .prog_word_i(pw),
        .data_bus_o(db), .prog_bus_o(pb));
    dap_datapath u_dap_datapath (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd), .data_bus_i(db),
        .prog_bus_i(pb), .acc_o(acc), .product_o(prod), .store_data_o(sd), .store_valid_o(sv),
        .bit_cond_o(bc), .bit_valid_o(bv), .jump_addr_o(ja), .jump_valid_o(jv), .zero_o(zf),
        .neg_o(nf), .carry_o(cf));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            end_sim();
        end
    end
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, s);
            errors++;
        end
    endtask
    task automatic issue(input dap_pkg::dap_cmd_s c);
        logic [31:0] b, t, o;
        logic [32:0] w;
        logic        cy;
        cmd = c;
        if (c.valid) begin
            o = c.load_opnd ? {16'h0000, dw} : {16'h0000, e_opr};
            t = {{16{c.sign_extend_enable & dw[15]}}, dw} << (c.shift_amt > 16 ? 16 : c.shift_amt);
            case (c.psh_mode)
                2'h0: b = e_prd;
                2'h1: b = e_prd << 1;
                2'h2: b = e_prd << 4;
                default: b = $signed(e_prd) >>> 6;
            endcase
            if (!c.src_prod) b = t;
            w = (c.op == dap_pkg::DAP_OP_SUB) ? {1'b0, e_acc} - {1'b0, b} : {1'b0, e_acc} + {1'b0, b};
            cy = w[32] & (c.op == dap_pkg::DAP_OP_ADD || c.op == dap_pkg::DAP_OP_SUB);
            case (c.op)
                dap_pkg::DAP_OP_ADD: e_acc = e_acc + b;
                dap_pkg::DAP_OP_SUB: e_acc = e_acc - b;
                dap_pkg::DAP_OP_AND: e_acc = e_acc & b;
                dap_pkg::DAP_OP_OR:  e_acc = e_acc | b;
                dap_pkg::DAP_OP_XOR: e_acc = e_acc ^ b;
                dap_pkg::DAP_OP_LD:  e_acc = b;
                dap_pkg::DAP_OP_NRM: if (e_acc != 0 && e_acc[31] == e_acc[30]) e_acc = e_acc << 1;
                default: ;
            endcase
            if (c.op != dap_pkg::DAP_OP_NOP) begin
                e_zf = (e_acc == 32'h0000_0000);
                e_ng = e_acc[31];
                e_cy = cy;
            end
            if (c.mul_go) e_prd = c.mul_signed ? $signed({{16{o[15]}}, o[15:0]}) * $signed({{16{pw[15]}}, pw})
                : o * {16'h0000, pw};
            if (c.load_opnd) e_opr = dw;
            t = e_acc << c.store_shift;
            e_sd = c.store_high ? t[31:16] : t[15:0];
            e_bc = dw[15 - c.bit_sel];
            e_ja = e_acc[15:0];
        end
        @(negedge clk_i);
        chk("acc", e_acc, acc);
        chk("product", e_prd, prod);
        chk("flags", {29'h0, e_zf, e_ng, e_cy}, {29'h0, zf, nf, cf});
        chk("pulses", {29'h0, c.valid & c.store_go, c.valid & c.bit_test_go, c.valid & c.jump_go},
            {29'h0, sv, bv, jv});
        if (c.valid & c.store_go) chk("store", {16'h0, e_sd}, {16'h0, sd});
        if (c.valid & c.bit_test_go) chk("bit", {31'h0, e_bc}, {31'h0, bc});
        if (c.valid & c.jump_go) chk("jump", {16'h0, e_ja}, {16'h0, ja});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        dap_pkg::dap_cmd_s c;
        logic [31:0]       r;
        e_acc = 32'h0000_0000;
        e_prd = 32'h0000_0000;
        e_opr = 16'h0000;
        repeat (3) @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk("reset acc", 32'h0000_0000, acc);
        chk("reset product", 32'h0000_0000, prod);
        chk("reset flags", 32'h0000_0000, {29'h0, zf, nf, cf});
        // every shift amount with both fill modes on a negative operand, but a positive one for sign fill at sixteen; then four normalize steps
        for (int i = 0; i < 38; i++) begin
            c = '0;
            c.valid = 1'b1;
            c.op = (i < 34) ? dap_pkg::DAP_OP_LD : dap_pkg::DAP_OP_NRM;
            c.shift_amt = 5'(i >> 1);
            c.sign_extend_enable = i[0];
            dw = (i == 33) ? 16'h0001 : 16'h8001;
            issue(c);
        end
        $display("corner test done");
        for (int n = 0; n < 3000; n++) begin
            r = xs();
            c = dap_pkg::dap_cmd_s'(r[26:0]);
            c.valid = r[31] | r[30];
            if (c.store_go | c.bit_test_go | c.jump_go) c.op = dap_pkg::DAP_OP_NOP;
            r = xs();
            dw = r[15:0];
            pw = r[31:16];
            issue(c);
        end
        $display("random test done");
        end_sim();
    end
endmodule
